// ---- verilog/ascsd_pkg.sv ----
package ascsd_pkg;

    // Clock and link timing
    localparam int SYS_CLK_MHZ              = 25;
    localparam int SCLK_HALF_CYCLES         = 8;
    localparam int CONV_SCLK_PERIODS        = 20;
    localparam int CONV_MIN_CYCLES          = CONV_SCLK_PERIODS * 2 * SCLK_HALF_CYCLES;
    localparam int INTER_FRAME_IDLE_TIME_NS = 50;
    localparam int INTER_FRAME_IDLE_CYCLES_RAW =
        (INTER_FRAME_IDLE_TIME_NS * SYS_CLK_MHZ + 999) / 1000;
    localparam int INTER_FRAME_IDLE_CYCLES  =
        (INTER_FRAME_IDLE_CYCLES_RAW < 1) ? 1 : INTER_FRAME_IDLE_CYCLES_RAW;

    // Frame layout
    localparam int SAMPLE_W    = 8;
    localparam int FRAME_BITS  = 16;
    localparam int LEAD_ZEROS  = 3;
    localparam int FIRST_DATA_FALL = LEAD_ZEROS + 1;

    // Falling-edge counts that steer the power mode and data capture
    localparam logic [4:0] FRAME_FALLS      = 5'h10;
    localparam logic [4:0] GLITCH_FALLS     = 5'h02;
    localparam logic [4:0] STAY_ON_FALLS    = 5'h0a;
    localparam logic [4:0] SHORT_STOP_FALLS = 5'h0c;
    localparam logic [4:0] SLEEP_STOP_FALLS = 5'h04;
    localparam logic [4:0] LAST_DATA_FALL   = 5'h0b;
    localparam logic [4:0] GLITCH_STOP_FALLS = 5'h01;

    // Reset values
    localparam logic       RESET_SHUTDOWN = 1'h0;
    localparam logic [2:0] SYNC_HIGH_RST  = 3'h7;
    localparam logic [2:0] SYNC_LOW_RST   = 3'h0;

    typedef enum logic [3:0] {
        ASCSD_OFF  = 4'h1,
        ASCSD_WAKE = 4'h2,
        ASCSD_IDLE = 4'h4,
        ASCSD_CONV = 4'h8
    } ascsd_dev_st_t;

    typedef enum logic [3:0] {
        ASCSD_H_IDLE  = 4'h1,
        ASCSD_H_HIGH  = 4'h2,
        ASCSD_H_LOW   = 4'h4,
        ASCSD_H_QUIET = 4'h8
    } ascsd_host_st_t;

    typedef enum logic [1:0] {
        ASCSD_FRAME_FULL  = 2'h0,
        ASCSD_FRAME_SHORT = 2'h1,
        ASCSD_FRAME_SLEEP  = 2'h2,
        ASCSD_FRAME_GLITCH = 2'h3
    } ascsd_frame_t;

    // Power mode left behind by a frame that ends after cnt falling edges
    function automatic logic ascsd_ends_off(input logic was_off, input logic [4:0] cnt);
        logic off;
        off = was_off;
        if (cnt >= STAY_ON_FALLS) begin
            off = 1'h0;
        end else if (was_off || cnt >= GLITCH_FALLS) begin
            off = 1'h1;
        end
        return off;
    endfunction

endpackage

// ---- verilog/ascsd_link_if.sv ----
interface ascsd_link_if;
    logic chip_sel_n;
    logic shift_clk;
    logic serial_sample_out;
    logic serial_sample_oe;

    modport dev (
        input  chip_sel_n,
        input  shift_clk,
        output serial_sample_out,
        output serial_sample_oe
    );

    modport host (
        output chip_sel_n,
        output shift_clk,
        input  serial_sample_out,
        input  serial_sample_oe
    );
endinterface

// ---- verilog/ascsd_dev.sv ----
// Function
// - Rise between falls two and ten: shutdown
// - Shutdown entry aborts frame, floats output
// - Rise before second fall keeps mode
// - Fall in shutdown powers up, result garbage
// - Second frame after wake is valid
// - Wake frame ended before tenth: back off
// - Host holds select past tenth fall; glitch and sleep frames here rise after fall 1 and 4
// - Fully powered after sixteen wake cycles
// - Host runs one dummy frame after wake
// - Host keeps idle gap after dummy frame
// - Start mode unknown, dummy frame first
// - Host limits to one conversion per twenty
// - Host may rise between tenth and fifteenth
// - Three zeros, eight bits MSB first, zeros
// - Output driven from select fall to sixteen
// - Rise after tenth: stay on, abort
module ascsd_dev #(
    parameter int SAMPLE_W = ascsd_pkg::SAMPLE_W
) (
    // Clock and reset
    input  wire logic                sys_clk_in,
    input  wire logic                reset_in,
    // Link
    ascsd_link_if.dev                link,
    // User side
    input  wire logic [SAMPLE_W-1:0] sample_in,
    output logic                     analog_power_out,
    output logic                     shutdown_out,
    output logic                     fully_up_out,
    output logic                     frame_valid_out
);
    import ascsd_pkg::*;

    localparam int TRAIL_W = FRAME_BITS - LEAD_ZEROS - SAMPLE_W;

    // Pin synchronisers
    logic [2:0]      cs_sync_q;
    logic [2:0]      cs_sync_d;
    logic [2:0]      sck_sync_q;
    logic [2:0]      sck_sync_d;
    logic            cs_st_q;
    logic            cs_st_d;
    logic            sck_st_q;
    logic            sck_st_d;

    // Frame state
    ascsd_dev_st_t   st_q;
    ascsd_dev_st_t   st_d;
    logic [4:0]      cnt_q;
    logic [4:0]      cnt_d;
    logic [FRAME_BITS-1:0] shreg_q;
    logic [FRAME_BITS-1:0] shreg_d;
    logic            oe_q;
    logic            oe_d;
    logic            warm_q;
    logic            warm_d;
    logic            fully_q;
    logic            fully_d;
    logic            valid_q;
    logic            valid_d;
    logic            power_q;
    logic            power_d;
    logic            off_q;
    logic            off_d;

    logic            cs_fall;
    logic            cs_rise;
    logic            sck_fall;
    logic            ends_off;

    always_comb begin
        cs_sync_d  = {cs_sync_q[1:0], link.chip_sel_n};
        sck_sync_d = {sck_sync_q[1:0], link.shift_clk};
        cs_st_d    = (cs_sync_q[1] == cs_sync_q[2]) ? cs_sync_q[2] : cs_st_q;
        sck_st_d   = (sck_sync_q[1] == sck_sync_q[2]) ? sck_sync_q[2] : sck_st_q;
    end

    always_ff @(posedge sys_clk_in or posedge reset_in) begin
        if (reset_in) begin
            cs_sync_q  <= SYNC_HIGH_RST;
            sck_sync_q <= SYNC_HIGH_RST;
            cs_st_q    <= 1'h1;
            sck_st_q   <= 1'h1;
        end else begin
            cs_sync_q  <= cs_sync_d;
            sck_sync_q <= sck_sync_d;
            cs_st_q    <= cs_st_d;
            sck_st_q   <= sck_st_d;
        end
    end

    assign cs_fall  = cs_st_q & ~cs_st_d;
    assign cs_rise  = ~cs_st_q & cs_st_d;
    assign sck_fall = sck_st_q & ~sck_st_d & ~cs_st_d;
    assign ends_off = ascsd_ends_off(st_q == ASCSD_WAKE, cnt_q);

    always_comb begin
        st_d    = st_q;
        cnt_d   = cnt_q;
        shreg_d = shreg_q;
        oe_d    = oe_q;
        warm_d  = warm_q;
        fully_d = fully_q;
        valid_d = valid_q;
        power_d = power_q;
        off_d   = off_q;
        case (st_q)
            ASCSD_OFF, ASCSD_IDLE: begin
                if (cs_fall) begin
                    // Sample taken; output leaves high impedance
                    cnt_d   = 5'h00;
                    shreg_d = {{LEAD_ZEROS{1'h0}}, sample_in, {TRAIL_W{1'h0}}};
                    oe_d    = 1'h1;
                    if (st_q == ASCSD_OFF) begin
                        st_d    = ASCSD_WAKE;
                        power_d = 1'h1;
                        off_d   = 1'h0;
                        fully_d = 1'h0;
                        valid_d = 1'h0;
                    end else begin
                        st_d    = ASCSD_CONV;
                        valid_d = warm_q;
                        fully_d = warm_q;
                    end
                end
            end
            ASCSD_WAKE, ASCSD_CONV: begin
                if (cs_rise) begin
                    oe_d    = 1'h0;
                    shreg_d = '0;
                    if (ends_off) begin
                        st_d    = ASCSD_OFF;
                        power_d = 1'h0;
                        off_d   = 1'h1;
                        warm_d  = 1'h0;
                        fully_d = 1'h0;
                        valid_d = 1'h0;
                    end else begin
                        // Glitch or late rise: stay in normal mode
                        st_d = ASCSD_IDLE;
                        if (cnt_q >= STAY_ON_FALLS) begin
                            warm_d = 1'h1;
                        end
                    end
                end else if (sck_fall && cnt_q != FRAME_FALLS) begin
                    cnt_d   = cnt_q + 5'h01;
                    shreg_d = {shreg_q[FRAME_BITS-2:0], 1'h0};
                    if (cnt_d == FRAME_FALLS) begin
                        oe_d = 1'h0;
                        if (st_q == ASCSD_WAKE) begin
                            fully_d = 1'h1;
                        end
                    end
                end
            end
            default: begin
                st_d    = ASCSD_OFF;
                oe_d    = 1'h0;
                power_d = 1'h0;
                off_d   = 1'h1;
            end
        endcase
    end

    always_ff @(posedge sys_clk_in or posedge reset_in) begin
        if (reset_in) begin
            st_q    <= RESET_SHUTDOWN ? ASCSD_OFF : ASCSD_IDLE;
            cnt_q   <= 5'h00;
            shreg_q <= '0;
            oe_q    <= 1'h0;
            warm_q  <= 1'h0;
            fully_q <= 1'h0;
            valid_q <= 1'h0;
            power_q <= ~RESET_SHUTDOWN;
            off_q   <= RESET_SHUTDOWN;
        end else begin
            st_q    <= st_d;
            cnt_q   <= cnt_d;
            shreg_q <= shreg_d;
            oe_q    <= oe_d;
            warm_q  <= warm_d;
            fully_q <= fully_d;
            valid_q <= valid_d;
            power_q <= power_d;
            off_q   <= off_d;
        end
    end

    assign link.serial_sample_out = shreg_q[FRAME_BITS-1];
    assign link.serial_sample_oe  = oe_q;
    assign analog_power_out       = power_q;
    assign shutdown_out           = off_q;
    assign fully_up_out           = fully_q;
    assign frame_valid_out        = valid_q;

endmodule

// ---- verilog/ascsd_host.sv ----
module ascsd_host #(
    parameter int SAMPLE_W  = ascsd_pkg::SAMPLE_W,
    parameter int HALF_CYC  = ascsd_pkg::SCLK_HALF_CYCLES,
    parameter int CONV_CYC  = ascsd_pkg::CONV_MIN_CYCLES,
    parameter int QUIET_CYC = ascsd_pkg::INTER_FRAME_IDLE_CYCLES
) (
    // Clock and reset
    input  wire logic                 sys_clk_in,
    input  wire logic                 reset_in,
    // Link
    ascsd_link_if.host                link,
    // User side
    input  wire logic                 start_in,
    input  wire ascsd_pkg::ascsd_frame_t frame_kind_in,
    output logic                      busy_out,
    output logic [SAMPLE_W-1:0]       data_out,
    output logic                      data_valid_out,
    output logic                      dummy_done_out
);
    import ascsd_pkg::*;

    logic [2:0]          sd_sync_q;
    logic [2:0]          sd_sync_d;
    logic                sd_st_q;
    logic                sd_st_d;

    ascsd_host_st_t      st_q;
    ascsd_host_st_t      st_d;
    logic [15:0]         half_q;
    logic [15:0]         half_d;
    logic [15:0]         gap_q;
    logic [15:0]         gap_d;
    logic [4:0]          falls_q;
    logic [4:0]          falls_d;
    logic [4:0]          stop_q;
    logic [4:0]          stop_d;
    logic                cs_n_q;
    logic                cs_n_d;
    logic                sclk_q;
    logic                sclk_d;
    logic                warm_q;
    logic                warm_d;
    logic                off_q;
    logic                off_d;
    logic                dummy_q;
    logic                dummy_d;
    logic [SAMPLE_W-1:0] smp_q;
    logic [SAMPLE_W-1:0] smp_d;
    logic [SAMPLE_W-1:0] data_q;
    logic [SAMPLE_W-1:0] data_d;
    logic                valid_q;
    logic                valid_d;
    logic                dmy_done_q;
    logic                dmy_done_d;
    logic                busy_q;
    logic                busy_d;

    always_comb begin
        sd_sync_d = {sd_sync_q[1:0], link.serial_sample_out};
        sd_st_d   = (sd_sync_q[1] == sd_sync_q[2]) ? sd_sync_q[2] : sd_st_q;
    end

    always_ff @(posedge sys_clk_in or posedge reset_in) begin
        if (reset_in) begin
            sd_sync_q <= SYNC_LOW_RST;
            sd_st_q   <= 1'h0;
        end else begin
            sd_sync_q <= sd_sync_d;
            sd_st_q   <= sd_st_d;
        end
    end

    always_comb begin
        st_d       = st_q;
        half_d     = (half_q != 16'h0000) ? half_q - 16'h0001 : half_q;
        gap_d      = (gap_q != 16'h0000) ? gap_q - 16'h0001 : gap_q;
        falls_d    = falls_q;
        stop_d     = stop_q;
        cs_n_d     = cs_n_q;
        sclk_d     = sclk_q;
        warm_d     = warm_q;
        off_d      = off_q;
        dummy_d    = dummy_q;
        smp_d      = smp_q;
        data_d     = data_q;
        valid_d    = 1'h0;
        dmy_done_d = 1'h0;
        case (st_q)
            ASCSD_H_IDLE: begin
                // Conversion rate bounded by the gap counter
                if (start_in && gap_q == 16'h0000) begin
                    cs_n_d  = 1'h0;
                    falls_d = 5'h00;
                    half_d  = 16'(HALF_CYC - 1);
                    gap_d   = 16'(CONV_CYC - 1);
                    dummy_d = ~warm_q;
                    st_d    = ASCSD_H_HIGH;
                    case (frame_kind_in)
                        ASCSD_FRAME_SHORT: stop_d = SHORT_STOP_FALLS;
                        ASCSD_FRAME_SLEEP: stop_d = SLEEP_STOP_FALLS;
                        ASCSD_FRAME_GLITCH: stop_d = GLITCH_STOP_FALLS;
                        default:           stop_d = FRAME_FALLS;
                    endcase
                end
            end
            ASCSD_H_HIGH: begin
                if (half_q == 16'h0000) begin
                    half_d = 16'(HALF_CYC - 1);
                    if (falls_q == stop_q) begin
                        cs_n_d = 1'h1;
                        st_d   = ASCSD_H_QUIET;
                        half_d = 16'(QUIET_CYC - 1);
                        off_d  = ascsd_ends_off(off_q, stop_q);
                        // Glitch frame leaves the device as it was
                        warm_d = ~off_d && (stop_q >= STAY_ON_FALLS
                            || (stop_q < GLITCH_FALLS && warm_q));
                        if (stop_q > LAST_DATA_FALL) begin
                            data_d     = smp_q;
                            valid_d    = ~dummy_q;
                            dmy_done_d = dummy_q;
                        end
                    end else begin
                        sclk_d  = 1'h0;
                        falls_d = falls_q + 5'h01;
                        st_d    = ASCSD_H_LOW;
                        if (falls_d >= 5'(FIRST_DATA_FALL) && falls_d <= LAST_DATA_FALL) begin
                            smp_d = {smp_q[SAMPLE_W-2:0], sd_st_q};
                        end
                    end
                end
            end
            ASCSD_H_LOW: begin
                if (half_q == 16'h0000) begin
                    sclk_d = 1'h1;
                    half_d = 16'(HALF_CYC - 1);
                    st_d   = ASCSD_H_HIGH;
                end
            end
            ASCSD_H_QUIET: begin
                if (half_q == 16'h0000) begin
                    st_d = ASCSD_H_IDLE;
                end
            end
            default: begin
                st_d   = ASCSD_H_IDLE;
                cs_n_d = 1'h1;
                sclk_d = 1'h1;
            end
        endcase
        busy_d = (st_d != ASCSD_H_IDLE);
    end

    always_ff @(posedge sys_clk_in or posedge reset_in) begin
        if (reset_in) begin
            st_q       <= ASCSD_H_IDLE;
            half_q     <= 16'h0000;
            gap_q      <= 16'h0000;
            falls_q    <= 5'h00;
            stop_q     <= 5'h00;
            cs_n_q     <= 1'h1;
            sclk_q     <= 1'h1;
            warm_q     <= 1'h0;
            off_q      <= 1'h0;
            dummy_q    <= 1'h0;
            smp_q      <= '0;
            data_q     <= '0;
            valid_q    <= 1'h0;
            dmy_done_q <= 1'h0;
            busy_q     <= 1'h0;
        end else begin
            st_q       <= st_d;
            half_q     <= half_d;
            gap_q      <= gap_d;
            falls_q    <= falls_d;
            stop_q     <= stop_d;
            cs_n_q     <= cs_n_d;
            sclk_q     <= sclk_d;
            warm_q     <= warm_d;
            off_q      <= off_d;
            dummy_q    <= dummy_d;
            smp_q      <= smp_d;
            data_q     <= data_d;
            valid_q    <= valid_d;
            dmy_done_q <= dmy_done_d;
            busy_q     <= busy_d;
        end
    end

    assign link.chip_sel_n = cs_n_q;
    assign link.shift_clk  = sclk_q;
    assign busy_out        = busy_q;
    assign data_out        = data_q;
    assign data_valid_out  = valid_q;
    assign dummy_done_out  = dmy_done_q;

endmodule

// ---- tb/ascsd_link_asserts.sv ----
module ascsd_link_asserts (
    // Clock and reset
    input  wire logic sys_clk_in,
    input  wire logic reset_in,
    // Link
    input  wire logic chip_sel_n,
    input  wire logic shift_clk,
    input  wire logic serial_sample_out,
    input  wire logic serial_sample_oe
);
    timeunit 1ns;
    timeprecision 1ps;

    logic       sclk_q;
    logic [4:0] fcnt_q;
    logic [4:0] fcnt_d;
    logic [3:0] hi_q;
    logic [3:0] hi_d;
    logic       fall;

    // Falls since select fall, idle cycles since select rise
    always_comb begin
        fall = sclk_q && !shift_clk;
        fcnt_d = fcnt_q;
        hi_d = hi_q;
        if (chip_sel_n) begin
            fcnt_d = 5'h00;
            if (hi_q != 4'h8) begin
                hi_d = hi_q + 4'h1;
            end
        end else begin
            hi_d = 4'h0;
            if (fall && fcnt_q != 5'h1f) begin
                fcnt_d = fcnt_q + 5'h01;
            end
        end
    end

    always_ff @(posedge sys_clk_in or posedge reset_in) begin
        if (reset_in) begin
            sclk_q <= 1'h1;
            fcnt_q <= 5'h00;
            hi_q   <= 4'h0;
        end else begin
            sclk_q <= shift_clk;
            fcnt_q <= fcnt_d;
            hi_q   <= hi_d;
        end
    end

    default clocking cb @(posedge sys_clk_in);
    endclocking
    default disable iff (reset_in);

    chk_oe_on_fall: assert property ($fell(chip_sel_n) |-> ##[1:6] serial_sample_oe)
        else $error("output not driven after select fall");
    chk_oe_off_rise: assert property ($rose(chip_sel_n) |-> ##[1:6] !serial_sample_oe)
        else $error("output still driven after select rise");
    chk_idle_float: assert property (hi_q == 4'h8 |-> !serial_sample_oe)
        else $error("output driven while deselected");
    chk_drive_during: assert property (fall && !chip_sel_n && fcnt_q < 5'h0f
        |-> ##6 serial_sample_oe)
        else $error("output floated inside frame");
    chk_float_sixteen: assert property (fall && !chip_sel_n && fcnt_q == 5'h0f
        |-> ##[1:6] !serial_sample_oe)
        else $error("output driven after sixteenth fall");
    chk_zero_bits: assert property (fall && !chip_sel_n
        && (fcnt_q < 5'h02 || (fcnt_q > 5'h09 && fcnt_q < 5'h0f))
        |-> ##6 (!serial_sample_oe || !serial_sample_out))
        else $error("padding bit not zero");
    chk_lead_zero: assert property ($fell(chip_sel_n)
        |-> ##6 (!serial_sample_oe || !serial_sample_out))
        else $error("first bit not zero");
    chk_bit_steady: assert property ($rose(shift_clk) && !chip_sel_n
        |-> (!serial_sample_oe || $stable(serial_sample_out)) [*8])
        else $error("data bit moved between falls");

    cover property (fall && !chip_sel_n && fcnt_q == 5'h0f);
    cover property ($rose(chip_sel_n) && fcnt_q == 5'h04);
    cover property ($rose(chip_sel_n) && fcnt_q == 5'h0c);
    cover property ($rose(chip_sel_n) && fcnt_q == 5'h01);
endmodule

// ---- tb/testbench.sv ----
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import ascsd_pkg::*;

    logic         sys_clk_in;
    logic         reset_in;
    logic [7:0]   sample_in;
    logic         analog_power_out;
    logic         shutdown_out;
    logic         fully_up_out;
    logic         frame_valid_out;
    logic         start_in;
    ascsd_frame_t frame_kind_in;
    logic         busy_out;
    logic [7:0]   data_out;
    logic         data_valid_out;
    logic         dummy_done_out;
    int           err_total;
    int           num_checks;
    int           cyc;
    int           last_fall;
    int           gap;
    int           falls;
    int           frame_falls;
    logic         cs_q;
    logic         sck_q;
    logic         need_dummy;
    logic         off_exp;
    ascsd_frame_t seq [12] = '{ASCSD_FRAME_FULL, ASCSD_FRAME_FULL, ASCSD_FRAME_SHORT,
        ASCSD_FRAME_GLITCH, ASCSD_FRAME_SLEEP, ASCSD_FRAME_GLITCH, ASCSD_FRAME_SLEEP,
        ASCSD_FRAME_FULL, ASCSD_FRAME_FULL, ASCSD_FRAME_SLEEP, ASCSD_FRAME_SHORT,
        ASCSD_FRAME_SHORT};

    ascsd_link_if link();

    ascsd_dev u_ascsd_dev (.sys_clk_in, .reset_in, .link(link), .sample_in, .analog_power_out,
        .shutdown_out, .fully_up_out, .frame_valid_out);

    ascsd_host u_ascsd_host (.sys_clk_in, .reset_in, .link(link), .start_in, .frame_kind_in,
        .busy_out, .data_out, .data_valid_out, .dummy_done_out);

    ascsd_link_asserts u_ascsd_link_asserts (.sys_clk_in, .reset_in,
        .chip_sel_n(link.chip_sel_n), .shift_clk(link.shift_clk),
        .serial_sample_out(link.serial_sample_out), .serial_sample_oe(link.serial_sample_oe));

    always #20 sys_clk_in = ~sys_clk_in;

    // Wire monitor: falls per frame and select-fall spacing
    always @(negedge sys_clk_in) begin
        if (cs_q && !link.chip_sel_n) begin
            gap = cyc - last_fall;
            last_fall = cyc;
            falls = 0;
        end
        if (sck_q && !link.shift_clk && !link.chip_sel_n) falls++;
        if (!cs_q && link.chip_sel_n) frame_falls = falls;
        cs_q = link.chip_sel_n;
        sck_q = link.shift_clk;
        cyc++;
    end

    task automatic chk1(input logic got, input logic exp);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("Error %0t: flag %b expected %b", $time, got, exp);
        end
    endtask

    task automatic chkv(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("Error %0t: value %0h expected %0h", $time, got, exp);
        end
    endtask

    task automatic summarize;
        $display("checks %0d errors %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic timeout;
        err_total++;
        $display("Error %0t: wait ran out", $time);
        summarize;
    endtask

    task automatic frame(input ascsd_frame_t k);
        logic [7:0] s;
        logic [7:0] got;
        logic       was_off;
        int         n;
        int         tail;
        int         vseen;
        int         dseen;
        s = 8'($urandom);
        was_off = off_exp;
        got = 8'h00;
        @(negedge sys_clk_in);
        sample_in = s;
        frame_kind_in = k;
        start_in = 1'b1;
        n = 0;
        while (busy_out !== 1'b1) begin
            @(negedge sys_clk_in);
            n++;
            if (n > 1000) timeout;
        end
        start_in = 1'b0;
        n = 0;
        tail = 0;
        vseen = 0;
        dseen = 0;
        while (tail < 4) begin
            @(negedge sys_clk_in);
            n++;
            if (busy_out !== 1'b1) tail++;
            // Gap read one edge later, after the monitor has seen the fall
            if (n == 1) chk1(gap >= CONV_MIN_CYCLES, 1'b1);
            if (n == 40) chk1(frame_valid_out, !need_dummy);
            if (data_valid_out === 1'b1) begin
                vseen++;
                got = data_out;
            end
            if (dummy_done_out === 1'b1) dseen++;
            if (n > 1000) timeout;
        end
        if (k == ASCSD_FRAME_SLEEP) begin
            chkv(vseen + dseen, 0);
            chkv(frame_falls, 4);
            off_exp = 1'b1;
            need_dummy = 1'b1;
            chk1(fully_up_out, 1'b0);
        end else if (k == ASCSD_FRAME_GLITCH) begin
            chkv(vseen + dseen, 0);
            chkv(frame_falls, 1);
        end else begin
            chkv(dseen, need_dummy);
            chkv(vseen, !need_dummy);
            if (!need_dummy) chkv(got, s);
            chkv(frame_falls, (k == ASCSD_FRAME_FULL) ? 16 : 12);
            if (was_off && k == ASCSD_FRAME_FULL) chk1(fully_up_out, 1'b1);
            off_exp = 1'b0;
            need_dummy = 1'b0;
        end
        chk1(shutdown_out, off_exp);
        chk1(analog_power_out, !off_exp);
    endtask

    initial begin
        sys_clk_in = 1'b0;
        reset_in = 1'b1;
        start_in = 1'b0;
        sample_in = 8'h00;
        frame_kind_in = ASCSD_FRAME_FULL;
        err_total = 0;
        num_checks = 0;
        cyc = 0;
        last_fall = -100000;
        gap = 100000;
        falls = 0;
        frame_falls = 0;
        cs_q = 1'b1;
        sck_q = 1'b1;
        need_dummy = 1'b1;
        off_exp = RESET_SHUTDOWN;
        void'($urandom(67));
        repeat (10) @(posedge sys_clk_in);
        @(negedge sys_clk_in);
        reset_in = 1'b0;
        chk1(shutdown_out, RESET_SHUTDOWN);
        // Wake, abort, fall-back and stay-on paths in a fixed order
        foreach (seq[i]) frame(seq[i]);
        repeat (16) frame(ascsd_frame_t'($urandom_range(3)));
        summarize;
    end
endmodule
